// >>> rtl/ciexu_pkg.sv
// Package for the core interrupt and exception unit.
// Assumes a 32-bit Wishbone classic register bus and one core clock.
package ciexu_pkg;

  localparam int NVEC = 16;
  localparam int SYNC_W = 4;

  // Register byte offsets
  localparam logic [7:0] OFF_MSTATE = 8'h00;
  localparam logic [7:0] OFF_HWCFG = 8'h04;
  localparam logic [7:0] OFF_VPFX = 8'h08;
  localparam logic [7:0] OFF_NC_ADDR = 8'h0C;
  localparam logic [7:0] OFF_NC_STATE = 8'h10;
  localparam logic [7:0] OFF_CR_ADDR = 8'h14;
  localparam logic [7:0] OFF_CR_STATE = 8'h18;
  localparam logic [7:0] OFF_DB_ADDR = 8'h1C;
  localparam logic [7:0] OFF_DB_STATE = 8'h20;
  localparam logic [7:0] OFF_SYNDROME = 8'h24;
  localparam logic [7:0] OFF_MCHK_SYN = 8'h28;
  localparam logic [7:0] OFF_VFSC = 8'h2C;
  localparam logic [7:0] OFF_VOFF = 8'h40;

  // Machine state bit positions
  localparam int MS_EXT_EN = 15;
  localparam int MS_CE = 17;
  localparam int MS_ME = 12;
  localparam int MS_DE = 9;

  // Hardware configuration bit positions
  localparam int CFG_DUE = 0;
  localparam int CFG_DCLR_EXT = 1;
  localparam int CFG_DCLR_CE = 2;
  localparam int CFG_CCLR_DE = 3;
  localparam int CFG_MCLR_DE = 4;

  // Exception syndrome bit marking a saved next address
  localparam int SYN_AFTER = 0;

  // Reset values
  localparam logic [31:0] MS_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;

  // Vector offset register indices
  localparam logic [3:0] VEC_CRIT = 4'h0;
  localparam logic [3:0] VEC_MCHK = 4'h1;
  localparam logic [3:0] VEC_EXT = 4'h4;
  localparam logic [3:0] VEC_DBG = 4'hF;

  typedef enum logic [1:0] {KIND_AT, KIND_AFTER, KIND_FORCED, KIND_OTHER} ciexu_kind_t;
  typedef enum logic [1:0] {RET_NONE, RET_NC, RET_CR, RET_DB} ciexu_ret_t;
  typedef enum logic [1:0] {CLS_NONE, CLS_NC, CLS_CR, CLS_DB} ciexu_cls_t;

  typedef struct packed {
    logic valid;
    logic [3:0] vec;
    ciexu_kind_t kind;
    logic [31:0] syn;
    logic [31:0] pc_fault;
    logic [31:0] pc_next;
    logic [31:0] pc_start;
  } ciexu_exc_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } ciexu_wbreq_t;

  typedef struct packed {
    logic valid;
    ciexu_cls_t cls;
    logic [31:0] pc;
  } ciexu_redir_t;

endpackage : ciexu_pkg

// >>> rtl/ciexu_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous level inputs; output follows once stages two and three agree.
module ciexu_sync #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } ciexu_sync_st_t;

  ciexu_sync_st_t q;
  ciexu_sync_st_t next_q;

  always_comb begin
    next_q = q;
    next_q.s1 = d_i;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        next_q.o[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign q_o = q.o;

endmodule : ciexu_sync

// >>> rtl/ciexu_top.sv
// Interrupt and exception unit of a 32-bit core: class arbitration,
// save/restore registers, syndromes, vectoring, returns.
// Assumes core pipeline logic on clk_i and asynchronous request pins.
module ciexu_top #(
  parameter int NVEC = ciexu_pkg::NVEC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic ext_int_i,
  input wire logic crit_int_i,
  input wire logic mchk_int_i,
  input wire logic dbg_int_i,
  input wire logic [31:0] mchk_cause_i,
  input wire ciexu_pkg::ciexu_exc_t exc_i,
  input wire ciexu_pkg::ciexu_ret_t ret_i,
  output logic exc_ack_o,
  output ciexu_pkg::ciexu_redir_t redir_o,
  output logic illegal_o,
  output logic [31:0] machine_state_o
);

  typedef struct packed {
    logic [31:0] ms;
    logic [31:0] cfg;
    logic [31:0] vpfx;
    logic [31:0] nc_a;
    logic [31:0] nc_s;
    logic [31:0] cr_a;
    logic [31:0] cr_s;
    logic [31:0] db_a;
    logic [31:0] db_s;
    logic [31:0] exc_syn;
    logic [31:0] mchk_syn;
    logic [31:0] vfsc;
    logic [NVEC-1:0][11:0] voff;
    logic wb_ack;
    logic [31:0] wb_dat;
    ciexu_pkg::ciexu_redir_t redir;
    logic illegal;
    logic exc_ack;
  } ciexu_st_t;

  ciexu_st_t q;
  ciexu_st_t next_q;
  ciexu_pkg::ciexu_wbreq_t wb;
  logic [ciexu_pkg::SYNC_W-1:0] req_s;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // Vector offset window decode
  function automatic logic voff_hit(input logic [7:0] adr);
    logic [5:0] idx;
    idx = 6'(adr[7:2] - ciexu_pkg::OFF_VOFF[7:2]);
    return adr >= ciexu_pkg::OFF_VOFF && int'(idx) < NVEC;
  endfunction : voff_hit

  // Saved address for a synchronous exception
  function automatic logic [31:0] sync_addr(input ciexu_pkg::ciexu_exc_t e);
    logic [31:0] a;
    a = e.pc_fault;
    unique case (e.kind)
      ciexu_pkg::KIND_AT: a = e.pc_fault;
      ciexu_pkg::KIND_AFTER: a = e.pc_next;
      ciexu_pkg::KIND_FORCED: a = e.pc_fault;
      ciexu_pkg::KIND_OTHER: a = e.pc_start;
    endcase
    return a;
  endfunction : sync_addr

  assign wb.cyc = wb_cyc_i;
  assign wb.stb = wb_stb_i;
  assign wb.we = wb_we_i;
  assign wb.sel = wb_sel_i;
  assign wb.adr = wb_adr_i;
  assign wb.dat = wb_dat_i;

  ciexu_sync #(
    .W(ciexu_pkg::SYNC_W)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({dbg_int_i, mchk_int_i, crit_int_i, ext_int_i}),
    .q_o(req_s)
  );

  logic due;
  logic clr_dee;
  logic clr_dce;
  logic clr_cde;
  logic clr_mde;
  logic db_req;
  logic mc_req;
  logic cr_req;
  logic sy_req;
  logic ex_req;
  logic wr;
  logic [5:0] vidx;
  logic [3:0] tvec;
  logic [31:0] wmerge;

  always_comb begin
    next_q = q;
    tvec = ciexu_pkg::VEC_EXT;
    wmerge = 32'h0000_0000;
    due = q.cfg[ciexu_pkg::CFG_DUE];
    clr_dee = ~due | q.cfg[ciexu_pkg::CFG_DCLR_EXT];
    clr_dce = ~due | q.cfg[ciexu_pkg::CFG_DCLR_CE];
    clr_cde = ~due | q.cfg[ciexu_pkg::CFG_CCLR_DE];
    clr_mde = ~due | q.cfg[ciexu_pkg::CFG_MCLR_DE];
    db_req = req_s[3] & q.ms[ciexu_pkg::MS_DE];
    mc_req = req_s[2] & q.ms[ciexu_pkg::MS_ME];
    cr_req = req_s[1] & q.ms[ciexu_pkg::MS_CE];
    ex_req = req_s[0] & q.ms[ciexu_pkg::MS_EXT_EN];
    sy_req = exc_i.valid & ~q.exc_ack;
    wr = wb.cyc & wb.stb & wb.we & q.wb_ack;
    vidx = 6'(wb.adr[7:2] - ciexu_pkg::OFF_VOFF[7:2]);

    // Register bus slave
    next_q.wb_ack = wb.cyc & wb.stb & ~q.wb_ack;
    next_q.wb_dat = 32'h0000_0000;
    unique case (wb.adr)
      ciexu_pkg::OFF_MSTATE: next_q.wb_dat = q.ms;
      ciexu_pkg::OFF_HWCFG: next_q.wb_dat = q.cfg;
      ciexu_pkg::OFF_VPFX: next_q.wb_dat = q.vpfx;
      ciexu_pkg::OFF_NC_ADDR: next_q.wb_dat = q.nc_a;
      ciexu_pkg::OFF_NC_STATE: next_q.wb_dat = q.nc_s;
      ciexu_pkg::OFF_CR_ADDR: next_q.wb_dat = q.cr_a;
      ciexu_pkg::OFF_CR_STATE: next_q.wb_dat = q.cr_s;
      ciexu_pkg::OFF_DB_ADDR: next_q.wb_dat = q.db_a;
      ciexu_pkg::OFF_DB_STATE: next_q.wb_dat = q.db_s;
      ciexu_pkg::OFF_SYNDROME: next_q.wb_dat = q.exc_syn;
      ciexu_pkg::OFF_MCHK_SYN: next_q.wb_dat = q.mchk_syn;
      ciexu_pkg::OFF_VFSC: next_q.wb_dat = q.vfsc;
      default: begin
        if (voff_hit(wb.adr)) begin
          next_q.wb_dat = {16'h0000, q.voff[vidx], 4'h0};
        end
      end
    endcase
    if (wr) begin
      unique case (wb.adr)
        ciexu_pkg::OFF_MSTATE: next_q.ms = merge(q.ms, wb.dat, wb.sel);
        ciexu_pkg::OFF_HWCFG: next_q.cfg = merge(q.cfg, wb.dat, wb.sel);
        ciexu_pkg::OFF_VPFX: next_q.vpfx = merge(q.vpfx, wb.dat, wb.sel);
        ciexu_pkg::OFF_NC_ADDR: next_q.nc_a = merge(q.nc_a, wb.dat, wb.sel);
        ciexu_pkg::OFF_NC_STATE: next_q.nc_s = merge(q.nc_s, wb.dat, wb.sel);
        ciexu_pkg::OFF_CR_ADDR: next_q.cr_a = merge(q.cr_a, wb.dat, wb.sel);
        ciexu_pkg::OFF_CR_STATE: next_q.cr_s = merge(q.cr_s, wb.dat, wb.sel);
        ciexu_pkg::OFF_DB_ADDR: next_q.db_a = merge(q.db_a, wb.dat, wb.sel);
        ciexu_pkg::OFF_DB_STATE: next_q.db_s = merge(q.db_s, wb.dat, wb.sel);
        ciexu_pkg::OFF_SYNDROME: next_q.exc_syn = merge(q.exc_syn, wb.dat, wb.sel);
        ciexu_pkg::OFF_MCHK_SYN: next_q.mchk_syn = merge(q.mchk_syn, wb.dat, wb.sel);
        ciexu_pkg::OFF_VFSC: next_q.vfsc = merge(q.vfsc, wb.dat, wb.sel);
        default: begin
          if (voff_hit(wb.adr)) begin
            wmerge = merge({16'h0000, q.voff[vidx], 4'h0}, wb.dat, wb.sel);
            next_q.voff[vidx] = wmerge[15:4];
          end
        end
      endcase
    end

    // Pipeline side; hardware updates override a same-cycle bus write
    next_q.redir.valid = 1'b0;
    next_q.redir.cls = ciexu_pkg::CLS_NONE;
    next_q.illegal = 1'b0;
    next_q.exc_ack = 1'b0;
    if (ret_i != ciexu_pkg::RET_NONE) begin
      unique case (ret_i)
        ciexu_pkg::RET_NC: begin
          next_q.ms = q.nc_s;
          next_q.redir.pc = q.nc_a;
          next_q.redir.valid = 1'b1;
          next_q.redir.cls = ciexu_pkg::CLS_NC;
        end
        ciexu_pkg::RET_CR: begin
          next_q.ms = q.cr_s;
          next_q.redir.pc = q.cr_a;
          next_q.redir.valid = 1'b1;
          next_q.redir.cls = ciexu_pkg::CLS_CR;
        end
        ciexu_pkg::RET_DB: begin
          if (due) begin
            next_q.ms = q.db_s;
            next_q.redir.pc = q.db_a;
            next_q.redir.valid = 1'b1;
            next_q.redir.cls = ciexu_pkg::CLS_DB;
          end else begin
            next_q.illegal = 1'b1;
          end
        end
        default: begin
          next_q.illegal = 1'b0;
        end
      endcase
    end else if (db_req) begin
      tvec = ciexu_pkg::VEC_DBG;
      next_q.redir.valid = 1'b1;
      if (due) begin
        next_q.db_a = exc_i.pc_next;
        next_q.db_s = q.ms;
        next_q.redir.cls = ciexu_pkg::CLS_DB;
      end else begin
        next_q.cr_a = exc_i.pc_next;
        next_q.cr_s = q.ms;
        next_q.redir.cls = ciexu_pkg::CLS_CR;
      end
      next_q.ms[ciexu_pkg::MS_DE] = 1'b0;
      next_q.ms[ciexu_pkg::MS_EXT_EN] = q.ms[ciexu_pkg::MS_EXT_EN] & ~clr_dee;
      next_q.ms[ciexu_pkg::MS_CE] = q.ms[ciexu_pkg::MS_CE] & ~clr_dce;
    end else if (mc_req) begin
      tvec = ciexu_pkg::VEC_MCHK;
      next_q.redir.valid = 1'b1;
      next_q.redir.cls = ciexu_pkg::CLS_CR;
      next_q.cr_a = exc_i.pc_next;
      next_q.cr_s = q.ms;
      next_q.mchk_syn = mchk_cause_i;
      next_q.ms[ciexu_pkg::MS_ME] = 1'b0;
      next_q.ms[ciexu_pkg::MS_CE] = 1'b0;
      next_q.ms[ciexu_pkg::MS_EXT_EN] = 1'b0;
      next_q.ms[ciexu_pkg::MS_DE] = q.ms[ciexu_pkg::MS_DE] & ~clr_mde;
    end else if (cr_req) begin
      tvec = ciexu_pkg::VEC_CRIT;
      next_q.redir.valid = 1'b1;
      next_q.redir.cls = ciexu_pkg::CLS_CR;
      next_q.cr_a = exc_i.pc_next;
      next_q.cr_s = q.ms;
      next_q.ms[ciexu_pkg::MS_CE] = 1'b0;
      next_q.ms[ciexu_pkg::MS_EXT_EN] = 1'b0;
      next_q.ms[ciexu_pkg::MS_DE] = q.ms[ciexu_pkg::MS_DE] & ~clr_cde;
    end else if (sy_req) begin
      tvec = exc_i.vec;
      next_q.redir.valid = 1'b1;
      next_q.redir.cls = ciexu_pkg::CLS_NC;
      next_q.exc_ack = 1'b1;
      next_q.nc_a = sync_addr(exc_i);
      next_q.nc_s = q.ms;
      next_q.exc_syn = exc_i.syn;
      next_q.exc_syn[ciexu_pkg::SYN_AFTER] = (exc_i.kind == ciexu_pkg::KIND_AFTER);
      next_q.ms[ciexu_pkg::MS_EXT_EN] = 1'b0;
    end else if (ex_req) begin
      tvec = ciexu_pkg::VEC_EXT;
      next_q.redir.valid = 1'b1;
      next_q.redir.cls = ciexu_pkg::CLS_NC;
      next_q.nc_a = exc_i.pc_next;
      next_q.nc_s = q.ms;
      next_q.ms[ciexu_pkg::MS_EXT_EN] = 1'b0;
    end
    if (ret_i == ciexu_pkg::RET_NONE && next_q.redir.valid) begin
      next_q.redir.pc = {q.vpfx[31:16], q.voff[tvec], 4'h0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ms <= ciexu_pkg::MS_RST;
      q.cfg <= ciexu_pkg::CFG_RST;
    end else begin
      q <= next_q;
    end
  end

  assign wb_ack_o = q.wb_ack;
  assign wb_dat_o = q.wb_dat;
  assign exc_ack_o = q.exc_ack;
  assign redir_o = q.redir;
  assign illegal_o = q.illegal;
  assign machine_state_o = q.ms;

endmodule : ciexu_top

// >>> testbench/ciexu_top_properties.sv
// Checker for the interrupt unit, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
module ciexu_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire ciexu_pkg::ciexu_ret_t ret_i,
  input wire logic exc_ack_o,
  input wire ciexu_pkg::ciexu_redir_t redir_o,
  input wire logic illegal_o,
  input wire logic [31:0] machine_state_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic was_ret;
  logic take;
  // Redirects that are not returns
  always_ff @(posedge clk_i) begin
    was_ret <= !rst_i && ret_i != ciexu_pkg::RET_NONE;
  end
  assign take = redir_o.valid && !was_ret;
  exc_redir_a: assert property (exc_ack_o |-> redir_o.valid)
    else $error("exception ack without redirect");
  one_exc_a: assert property (exc_ack_o |=> !exc_ack_o)
    else $error("exception ack longer than one cycle");
  vec_align_a: assert property (take |-> redir_o.pc[3:0] == 4'h0)
    else $error("vector address not aligned");
  nc_clear_a: assert property (take && redir_o.cls == ciexu_pkg::CLS_NC
    |-> !machine_state_o[ciexu_pkg::MS_EXT_EN]) else $error("external enable kept");
  nc_mask_a: assert property (take && redir_o.cls == ciexu_pkg::CLS_NC && !exc_ack_o
    |-> $past(machine_state_o[ciexu_pkg::MS_EXT_EN])) else $error("masked interrupt taken");
  illegal_a: assert property (illegal_o |-> !redir_o.valid && $stable(machine_state_o))
    else $error("illegal return changed state");
  ret_resume_a: assert property (ret_i inside {ciexu_pkg::RET_NC, ciexu_pkg::RET_CR}
    |=> redir_o.valid) else $error("return without redirect");
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
endmodule : ciexu_props
bind ciexu_top ciexu_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ret_i,
  .exc_ack_o, .redir_o, .illegal_o, .machine_state_o);

// >>> testbench/ciexu_pipe_model.sv
// Pipeline model: one synchronous exception per go pulse.
// Assumes the unit answers on exc_ack_i; the bench holds the fields.
module ciexu_pipe_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire ciexu_pkg::ciexu_kind_t kind_i,
  input wire logic [31:0] pc_i,
  input wire logic exc_ack_i,
  output ciexu_pkg::ciexu_exc_t exc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pend = 1'h0;
  // Request held until answered, dropped in the answer cycle
  always @(posedge clk_i) begin
    if (rst_i || exc_ack_i) begin
      pend <= 1'h0;
    end else if (go_i) begin
      pend <= 1'h1;
    end
  end
  assign exc_o = '{pend & ~exc_ack_i, 4'h5, kind_i, 32'h0000_0F00, pc_i, pc_i + 32'h4,
    pc_i + 32'h8};
endmodule : ciexu_pipe_model

// >>> testbench/tb_ciexu_top.sv
// Self-checking bench for the interrupt and exception unit.
// Assumes the pipeline model and the bound checker are compiled with it.
module tb_ciexu_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] PC = 32'h0000_1000;
  localparam logic [31:0] NX = 32'h0000_1004;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_ack_o, exc_ack, illegal, ill, go = 1'h0;
  logic ext = 1'h0, crit = 1'h0, mchk = 1'h0, dbg = 1'h0;
  logic [31:0] wb_dat_o, ms, rd, a, mcause = 32'h0;
  ciexu_pkg::ciexu_wbreq_t wb = '0;
  ciexu_pkg::ciexu_ret_t ret = ciexu_pkg::RET_NONE;
  ciexu_pkg::ciexu_kind_t kind = ciexu_pkg::KIND_AT;
  ciexu_pkg::ciexu_exc_t exc;
  ciexu_pkg::ciexu_redir_t redir, seen;
  ciexu_pkg::ciexu_cls_t cls_q[$];
  int fails = 0;
  int tests_run = 0;
  ciexu_pipe_model pipe (.clk_i, .rst_i, .go_i(go), .kind_i(kind), .pc_i(PC),
    .exc_ack_i(exc_ack), .exc_o(exc));
  ciexu_top uut (.clk_i, .rst_i, .wb_cyc_i(wb.cyc), .wb_stb_i(wb.stb), .wb_we_i(wb.we),
    .wb_sel_i(wb.sel), .wb_adr_i(wb.adr), .wb_dat_i(wb.dat), .wb_ack_o, .wb_dat_o,
    .ext_int_i(ext), .crit_int_i(crit), .mchk_int_i(mchk), .dbg_int_i(dbg),
    .mchk_cause_i(mcause), .exc_i(exc), .ret_i(ret), .exc_ack_o(exc_ack),
    .redir_o(redir), .illegal_o(illegal), .machine_state_o(ms));
  always #20 clk_i = ~clk_i;
  // Log of every fetch redirect
  always @(posedge clk_i) begin
    if (redir.valid === 1'h1) begin
      seen = redir;
      cls_q.push_back(redir.cls);
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
    wb <= '{1'h1, 1'h1, w, 4'hF, ad, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb.cyc <= 1'h0;
    wb.stb <= 1'h0;
    @(posedge clk_i);
  endtask : acc
  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    acc(1'h0, ad, 32'h0);
    check(rd, exp);
  endtask : rdc
  task automatic do_reset();
    rst_i <= 1'h1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    cls_q.delete();
    @(posedge clk_i);
  endtask : do_reset
  task automatic wait_n(input int n);
    while (cls_q.size() < n) @(posedge clk_i);
  endtask : wait_n
  task automatic do_ret(input ciexu_pkg::ciexu_ret_t r);
    ret <= r;
    @(posedge clk_i);
    ret <= ciexu_pkg::RET_NONE;
    @(posedge clk_i);
    ill = illegal;
    @(posedge clk_i);
  endtask : do_ret
  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    results();
  end
  initial begin
    do_reset();
    rdc(8'h00, ciexu_pkg::MS_RST);
    rdc(8'h04, ciexu_pkg::CFG_RST);
    rdc(8'h3C, 32'h0);
    acc(1'h1, 8'h08, 32'hABCD_0000);
    acc(1'h1, 8'h54, 32'h0000_0120);
    for (int k = 0; k < 4; k++) begin
      a = PC + (k == 1 ? 32'h4 : (k == 3 ? 32'h8 : 32'h0));
      acc(1'h1, 8'h24, 32'hFFFF_FFFF);
      acc(1'h1, 8'h00, 32'h0000_8000);
      cls_q.delete();
      kind <= ciexu_pkg::ciexu_kind_t'(k);
      go <= 1'h1;
      @(posedge clk_i);
      go <= 1'h0;
      wait_n(1);
      check(seen.pc, 32'hABCD_0120);
      rdc(8'h0C, a);
      rdc(8'h24, 32'h0000_0F00 | 32'(k == 1));
      rdc(8'h10, 32'h0000_8000);
      rdc(8'h00, 32'h0);
      do_ret(ciexu_pkg::RET_NC);
      check(seen.pc, a);
      rdc(8'h00, 32'h0000_8000);
    end
    $display("sync exception test done");
    do_reset();
    acc(1'h1, 8'h08, 32'hABCD_0000);
    acc(1'h1, 8'h50, 32'h0000_0340);
    acc(1'h1, 8'h40, 32'h0000_0560);
    ext <= 1'h1;
    repeat (10) @(posedge clk_i);
    check(32'(cls_q.size()), 32'h0);
    acc(1'h1, 8'h00, 32'h0002_8000);
    wait_n(1);
    check(seen.pc, 32'hABCD_0340);
    rdc(8'h0C, NX);
    crit <= 1'h1;
    wait_n(2);
    check(32'(seen.cls), 32'(ciexu_pkg::CLS_CR));
    rdc(8'h14, NX);
    rdc(8'h18, 32'h0002_0000);
    rdc(8'h00, 32'h0);
    ext <= 1'h0;
    crit <= 1'h0;
    repeat (8) @(posedge clk_i);
    do_ret(ciexu_pkg::RET_CR);
    rdc(8'h00, 32'h0002_0000);
    $display("external and critical test done");
    do_reset();
    acc(1'h1, 8'h00, 32'h0002_8200);
    dbg <= 1'h1;
    wait_n(1);
    check(32'(seen.cls), 32'(ciexu_pkg::CLS_CR));
    rdc(8'h18, 32'h0002_8200);
    rdc(8'h00, 32'h0);
    dbg <= 1'h0;
    repeat (8) @(posedge clk_i);
    do_ret(ciexu_pkg::RET_DB);
    check(32'(ill), 32'h1);
    acc(1'h1, 8'h04, 32'h0000_0001);
    acc(1'h1, 8'h00, 32'h0002_8200);
    cls_q.delete();
    dbg <= 1'h1;
    crit <= 1'h1;
    repeat (12) @(posedge clk_i);
    check(32'(cls_q.size()), 32'h2);
    check(32'(cls_q[0]), 32'(ciexu_pkg::CLS_DB));
    rdc(8'h1C, NX);
    rdc(8'h20, 32'h0002_8200);
    rdc(8'h18, 32'h0002_8000);
    dbg <= 1'h0;
    crit <= 1'h0;
    repeat (8) @(posedge clk_i);
    do_ret(ciexu_pkg::RET_CR);
    do_ret(ciexu_pkg::RET_DB);
    check(32'(ill), 32'h0);
    rdc(8'h00, 32'h0002_8200);
    $display("debug test done");
    do_reset();
    acc(1'h1, 8'h00, 32'h0000_1000);
    mcause <= 32'h0000_00A5;
    mchk <= 1'h1;
    wait_n(1);
    rdc(8'h28, 32'h0000_00A5);
    rdc(8'h14, NX);
    mchk <= 1'h0;
    $display("machine check test done");
    results();
  end
endmodule : tb_ciexu_top
